// ===== shared/lcc_map.svh
// Register offsets, field positions and reset values for the channel configuration bank
`ifndef LCC_MAP_SVH
`define LCC_MAP_SVH
// ==========================================
// Offsets
`define LCC_ADDR_CH1_CONFIG 8'h08
`define LCC_ADDR_CH2_CONFIG 8'h09
`define LCC_ADDR_CH3_CONFIG 8'h0A
// ==========================================
// Fields
`define LCC_FADER_MSB 7
`define LCC_FADER_LSB 5
`define LCC_PROP_BIT 4
`define LCC_CURVE_BIT 3
`define LCC_SUPPLY_BIT 2
`define LCC_CONFIG_RESET 8'h00
`define LCC_CONFIG_WMASK 8'hFF
// ==========================================
// Fader codes
`define LCC_FADER_NONE 3'h0
`define LCC_FADER_ONE 3'h1
`define LCC_FADER_TWO 3'h2
`define LCC_FADER_THREE 3'h3
`define LCC_FADER_PWM 3'h5
`define LCC_FULL_SCALE 8'hFF
`endif

// ===== shared/lcc_pkg.sv
// Types shared by the channel configuration bank
package lcc_pkg;
  typedef logic [7:0] lcc_byte_t;
  typedef logic [11:0] lcc_duty_t;
  typedef enum logic [1:0] {LCC_SRC_NONE, LCC_SRC_REG, LCC_SRC_PWM} lcc_src_t;
endpackage

// ===== rtl/lcc_channel_shape.sv
// One channel: fader scaling followed by the brightness curve
`timescale 1ns/10ps
`include "lcc_map.svh"
module lcc_channel_shape (
  input wire logic ref_clk,
  input wire logic rst,
  input wire lcc_pkg::lcc_byte_t configByte,
  input wire lcc_pkg::lcc_duty_t dutyIn,
  input wire lcc_pkg::lcc_byte_t fader1,
  input wire lcc_pkg::lcc_byte_t fader2,
  input wire lcc_pkg::lcc_byte_t fader3,
  input wire lcc_pkg::lcc_byte_t pwmFader,
  input wire lcc_pkg::lcc_byte_t groupScale,
  output lcc_pkg::lcc_duty_t dutyOut,
  output logic extSupply
);
  import lcc_pkg::*;
  typedef struct packed {
    lcc_duty_t duty;
    logic ext;
  } lcc_shape_state_t;
  lcc_shape_state_t state_reg;
  lcc_shape_state_t state_next;
  lcc_byte_t faderLevel;
  lcc_duty_t scaled;
  lcc_duty_t ratioed;
  logic [23:0] sq;

  // Scale by an 8-bit level, keeping the upper twelve bits of the product
  function automatic lcc_duty_t scaleBy(input lcc_duty_t d, input lcc_byte_t k);
    logic [19:0] p;
    p = d * k;
    return p[19:8];
  endfunction

  // ==========================================
  // Datapath
  always_comb begin
    case (configByte[`LCC_FADER_MSB:`LCC_FADER_LSB])
      `LCC_FADER_ONE: faderLevel = fader1;
      `LCC_FADER_TWO: faderLevel = fader2;
      `LCC_FADER_THREE: faderLevel = fader3;
      `LCC_FADER_PWM: faderLevel = pwmFader;
      default: faderLevel = `LCC_FULL_SCALE;
    endcase
    scaled = (faderLevel == `LCC_FULL_SCALE) ? dutyIn : scaleBy(dutyIn, faderLevel);
    // Same group scale on every channel keeps the colour mix
    ratioed = configByte[`LCC_PROP_BIT] ? scaleBy(scaled, groupScale) : scaled;
    // Square law approximates the exponential curve cheaply
    sq = ratioed * ratioed;
    state_next.duty = configByte[`LCC_CURVE_BIT] ? sq[23:12] : ratioed;
    state_next.ext = configByte[`LCC_SUPPLY_BIT];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dutyOut = state_reg.duty;
  assign extSupply = state_reg.ext;
endmodule

// ===== rtl/lcc_config_regs.sv
// Configuration registers for LED channels one to three with their shaping
`timescale 1ns/10ps
`include "lcc_map.svh"
// Summary of operation
// - Bits 7:5 codes 1h, 2h, 3h pick global fader one, two, three.
// - Fader field zero, the reset value, applies no fader scaling.
// - Fader code 5h scales by the level from the PWM input pin.
// - Codes 4h, 6h, 7h behave as code zero, no scaling.
// - Bit 4 set enables ratiometric dimming; cleared, the reset value, disables it.
// - Ratiometric channels scale proportionally, so mixed colour stays constant.
// - Bit 3 picks the curve: zero linear at reset, one exponential.
// - The curve applies to engine duties and host-written duties alike.
// - Bit 2 picks supply: zero charge pump at reset, one external.
// - Registers live at 8h, 9h, Ah and read zero after reset.
module lcc_config_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic regWrite,
  input wire lcc_pkg::lcc_byte_t regAddr,
  input wire lcc_pkg::lcc_byte_t regWdata,
  output lcc_pkg::lcc_byte_t regRdata,
  output logic regHit,
  input wire lcc_pkg::lcc_duty_t engineDuty1,
  input wire lcc_pkg::lcc_duty_t engineDuty2,
  input wire lcc_pkg::lcc_duty_t engineDuty3,
  input wire lcc_pkg::lcc_duty_t hostDuty1,
  input wire lcc_pkg::lcc_duty_t hostDuty2,
  input wire lcc_pkg::lcc_duty_t hostDuty3,
  input wire logic [2:0] engineOwns,
  input wire lcc_pkg::lcc_byte_t fader1,
  input wire lcc_pkg::lcc_byte_t fader2,
  input wire lcc_pkg::lcc_byte_t fader3,
  input wire lcc_pkg::lcc_byte_t pwmFader,
  input wire lcc_pkg::lcc_byte_t groupScale,
  output lcc_pkg::lcc_duty_t ch1Duty,
  output lcc_pkg::lcc_duty_t ch2Duty,
  output lcc_pkg::lcc_duty_t ch3Duty,
  output logic [2:0] extSupply
);
  import lcc_pkg::*;
  typedef struct packed {
    lcc_byte_t cfg1;
    lcc_byte_t cfg2;
    lcc_byte_t cfg3;
    lcc_byte_t rdata;
  } lcc_regs_state_t;
  lcc_regs_state_t state_reg;
  lcc_regs_state_t state_next;
  lcc_duty_t src1;
  lcc_duty_t src2;
  lcc_duty_t src3;
  logic [1:0] addrSel;
  logic wrCh1;
  logic wrCh2;
  logic wrCh3;
  logic [2:0] ch1FaderSelect;
  logic [2:0] ch2FaderSelect;
  logic [2:0] ch3FaderSelect;
  logic ch1ProportionalDim;
  logic ch2ProportionalDim;
  logic ch3ProportionalDim;
  logic ch1CurveSelect;
  logic ch2CurveSelect;
  logic ch3CurveSelect;
  logic ch1SupplySelect;
  logic ch2SupplySelect;
  logic ch3SupplySelect;
  lcc_byte_t shapeCfg1;
  lcc_byte_t shapeCfg2;
  lcc_byte_t shapeCfg3;

  function automatic logic [1:0] decode(input lcc_byte_t a);
    case (a)
      `LCC_ADDR_CH1_CONFIG: decode = 2'h1;
      `LCC_ADDR_CH2_CONFIG: decode = 2'h2;
      `LCC_ADDR_CH3_CONFIG: decode = 2'h3;
      default: decode = 2'h0;
    endcase
  endfunction

  // Unused codes fold to the no-fader code so every shaper sees one idle code
  function automatic logic [2:0] faderFold(input lcc_byte_t c);
    case (c[`LCC_FADER_MSB:`LCC_FADER_LSB])
      `LCC_FADER_ONE: faderFold = `LCC_FADER_ONE;
      `LCC_FADER_TWO: faderFold = `LCC_FADER_TWO;
      `LCC_FADER_THREE: faderFold = `LCC_FADER_THREE;
      `LCC_FADER_PWM: faderFold = `LCC_FADER_PWM;
      default: faderFold = `LCC_FADER_NONE;
    endcase
  endfunction

  // Bits 1:0 are kept for readback only and never reach the datapath
  function automatic lcc_byte_t shaperByte(
    input logic [2:0] fader,
    input logic prop,
    input logic curve,
    input logic supply
  );
    shaperByte = {fader, prop, curve, supply, 2'h0};
  endfunction

  // ==========================================
  // Address decode and write strobes
  assign addrSel = decode(regAddr);
  // Writes to unmapped addresses raise no strobe and are dropped
  assign wrCh1 = regWrite && (addrSel == 2'h1);
  assign wrCh2 = regWrite && (addrSel == 2'h2);
  assign wrCh3 = regWrite && (addrSel == 2'h3);
  assign regHit = (addrSel != 2'h0);

  // ==========================================
  // Register file
  always_comb begin
    state_next = state_reg;
    if (wrCh1) begin
      state_next.cfg1 = regWdata & `LCC_CONFIG_WMASK;
    end
    if (wrCh2) begin
      state_next.cfg2 = regWdata & `LCC_CONFIG_WMASK;
    end
    if (wrCh3) begin
      state_next.cfg3 = regWdata & `LCC_CONFIG_WMASK;
    end
    // Read data is registered; unmapped addresses return zero
    case (addrSel)
      2'h1: state_next.rdata = state_next.cfg1;
      2'h2: state_next.rdata = state_next.cfg2;
      2'h3: state_next.rdata = state_next.cfg3;
      default: state_next.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= {`LCC_CONFIG_RESET, `LCC_CONFIG_RESET, `LCC_CONFIG_RESET, 8'h00};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Field decode
  // Readback keeps the raw code; only the shapers see the folded one
  assign ch1FaderSelect = faderFold(state_reg.cfg1);
  assign ch2FaderSelect = faderFold(state_reg.cfg2);
  assign ch3FaderSelect = faderFold(state_reg.cfg3);

  assign ch1ProportionalDim = state_reg.cfg1[`LCC_PROP_BIT];
  assign ch2ProportionalDim = state_reg.cfg2[`LCC_PROP_BIT];
  assign ch3ProportionalDim = state_reg.cfg3[`LCC_PROP_BIT];

  assign ch1CurveSelect = state_reg.cfg1[`LCC_CURVE_BIT];
  assign ch2CurveSelect = state_reg.cfg2[`LCC_CURVE_BIT];
  assign ch3CurveSelect = state_reg.cfg3[`LCC_CURVE_BIT];

  assign ch1SupplySelect = state_reg.cfg1[`LCC_SUPPLY_BIT];
  assign ch2SupplySelect = state_reg.cfg2[`LCC_SUPPLY_BIT];
  assign ch3SupplySelect = state_reg.cfg3[`LCC_SUPPLY_BIT];

  assign shapeCfg1 = shaperByte(
    ch1FaderSelect, ch1ProportionalDim, ch1CurveSelect, ch1SupplySelect
  );
  assign shapeCfg2 = shaperByte(
    ch2FaderSelect, ch2ProportionalDim, ch2CurveSelect, ch2SupplySelect
  );
  assign shapeCfg3 = shaperByte(
    ch3FaderSelect, ch3ProportionalDim, ch3CurveSelect, ch3SupplySelect
  );

  // ==========================================
  // Outputs
  assign regRdata = state_reg.rdata;

  // ==========================================
  // Channel shaping
  // One shaper per channel serves engine and host duties alike
  assign src1 = engineOwns[0] ? engineDuty1 : hostDuty1;
  assign src2 = engineOwns[1] ? engineDuty2 : hostDuty2;
  assign src3 = engineOwns[2] ? engineDuty3 : hostDuty3;

  lcc_channel_shape uShape1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .configByte(shapeCfg1),
    .dutyIn(src1),
    .fader1(fader1),
    .fader2(fader2),
    .fader3(fader3),
    .pwmFader(pwmFader),
    .groupScale(groupScale),
    .dutyOut(ch1Duty),
    .extSupply(extSupply[0])
  );

  lcc_channel_shape uShape2 (
    .ref_clk(ref_clk),
    .rst(rst),
    .configByte(shapeCfg2),
    .dutyIn(src2),
    .fader1(fader1),
    .fader2(fader2),
    .fader3(fader3),
    .pwmFader(pwmFader),
    .groupScale(groupScale),
    .dutyOut(ch2Duty),
    .extSupply(extSupply[1])
  );

  lcc_channel_shape uShape3 (
    .ref_clk(ref_clk),
    .rst(rst),
    .configByte(shapeCfg3),
    .dutyIn(src3),
    .fader1(fader1),
    .fader2(fader2),
    .fader3(fader3),
    .pwmFader(pwmFader),
    .groupScale(groupScale),
    .dutyOut(ch3Duty),
    .extSupply(extSupply[2])
  );
endmodule

// ===== verification/lcc_config_regs_chk.sv
// Port assertions for the config bank
`timescale 1ns/10ps
module lcc_config_regs_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic regWrite,
  input wire lcc_pkg::lcc_byte_t regAddr,
  input wire lcc_pkg::lcc_byte_t regWdata,
  input wire lcc_pkg::lcc_byte_t regRdata,
  input wire logic regHit,
  input wire logic [2:0] extSupply
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  hit_map_a: assert property (regHit == regAddr inside {[8'h08:8'h0A]})
    else $error("hit");
  miss_zero_a: assert property (!regHit |=> !regRdata) else $error("miss");
  write_back_a: assert property (regWrite && regHit |=> regRdata == $past(regWdata))
    else $error("back");
  read_hold_a: assert property (!regWrite && $stable(regAddr) |=> $stable(regRdata))
    else $error("hold");
  reset_zero_a: assert property ($past(rst) && !regWrite |=> !regRdata && !extSupply)
    else $error("reset");
  supply_hold_a: assert property (!regWrite [*2] |=> $stable(extSupply))
    else $error("sup");
  supply_set_a: assert property (regWrite && regAddr == 8'h0A && regWdata[2]
    ##1 !regWrite [*2] |=> extSupply[2]) else $error("set");
  supply_clr_a: assert property (regWrite && regAddr == 8'h09 && !regWdata[2]
    ##1 !regWrite [*2] |=> !extSupply[1]) else $error("clr");
  cover property (regWrite && !regHit);
  cover property (regWrite ##1 regWrite);
  cover property (extSupply == 3'h7);
endmodule
bind lcc_config_regs lcc_config_regs_chk chk (.ref_clk(ref_clk), .rst(rst), .regWrite(regWrite),
  .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
  .extSupply(extSupply));

// ===== verification/lcc_config_regs_tb.sv
// Bench for the config bank
`timescale 1ns/10ps
module lcc_config_regs_tb;
  import lcc_pkg::*;
  logic ref_clk = 1'b0, rst, regWrite, regHit;
  logic [2:0] own, extSupply;
  lcc_byte_t regAddr, regWdata, regRdata, f1, f2, f3, pw, gs, cfg [256] = '{default: 8'h00};
  lcc_duty_t eD [3] = '{3{12'h000}}, hD [3] = '{3{12'h000}}, dOut [3];
  int errors = 0, samples_checked = 0, i, j, seed = 32'h27F65411;
  lcc_config_regs dut (.ref_clk(ref_clk), .rst(rst), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit), .engineDuty1(eD[0]),
    .engineDuty2(eD[1]), .engineDuty3(eD[2]), .hostDuty1(hD[0]), .hostDuty2(hD[1]),
    .hostDuty3(hD[2]), .engineOwns(own), .fader1(f1), .fader2(f2), .fader3(f3),
    .pwmFader(pw), .groupScale(gs), .ch1Duty(dOut[0]), .ch2Duty(dOut[1]),
    .ch3Duty(dOut[2]), .extSupply(extSupply));
  function automatic lcc_duty_t shape(lcc_byte_t c, lcc_duty_t d);
    lcc_byte_t fl [8];
    logic [23:0] v;
    fl = '{8'hFF, f1, f2, f3, 8'hFF, pw, 8'hFF, 8'hFF};
    v = fl[c[7:5]] == 8'hFF ? d : d * fl[c[7:5]] >> 8;
    if (c[4]) v = v * gs >> 8;
    if (c[3]) v = v * v >> 12;
    return v[11:0];
  endfunction
  task cmpDuty(input lcc_duty_t got, exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %0t duty %h expected %h", $time, got, exp);
    end
  endtask
  task cmpReg(input lcc_byte_t got, exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task cmpFlag(input logic [2:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %0t flags %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input lcc_byte_t x, d);
    regWrite = 1'b1;
    {regAddr, regWdata} = {x, d};
    if (x inside {[8'h08:8'h0A]}) cfg[x] = d;
    @(negedge ref_clk);
  endtask
  task rd(input lcc_byte_t x);
    regAddr = x;
    @(negedge ref_clk);
    cmpReg(regRdata, cfg[x]);
    cmpFlag({2'h0, regHit}, {2'h0, (x inside {[8'h08:8'h0A]})});
  endtask
  task conclude;
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #50 ref_clk = ~ref_clk;
  initial begin
    rst = 1'b1;
    {regWrite, regAddr, regWdata, own, f1, f2, f3, pw, gs} = 60'h0;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    // Unmapped places at both ends read zero too
    for (i = 7; i < 12; i++) rd(8'(i));
    for (i = 0; i < 300; i++) begin
      wr(8'h07 + 8'({$random(seed)} % 5), 8'($random(seed)));
      wr(8'h08 + 8'({$random(seed)} % 3), 8'($random(seed)));
      regWrite = 1'b0;
      {f1, f3, pw, gs} = $random(seed);
      f2 = i[2] ? 8'hFF : 8'($random(seed));
      own = 3'($random(seed));
      for (j = 0; j < 3; j++) {eD[j], hD[j]} = 24'($random(seed));
      repeat (2) @(negedge ref_clk);
      for (j = 0; j < 3; j++)
        cmpDuty(dOut[j], shape(cfg[8 + j], own[j] ? eD[j] : hD[j]));
      cmpFlag(extSupply, {cfg[10][2], cfg[9][2], cfg[8][2]});
      for (j = 8; j < 11; j++) rd(8'(j));
    end
    conclude;
  end
endmodule
